// *** common/fbrl_pkg.sv ***
// Notes on behaviour
// RULE_01 - Host programs 9 initial waits above 95 MHz, 10 above 104 MHz.
// RULE_02 - Continuous/16-word: first 8-word crossing waits max(0, N-(8-w)).
// RULE_03 - Latency settings 8 through 13 count as 8 for that crossing.
// RULE_04 - 128-word crossing adds 0 for 3..8, 1 for 9, 2 for 10..13.
// RULE_05 - Continuous bursts run on, wrapping to zero, until terminated.
// RULE_06 - Entering an idle bank applies the boundary-crossing latency.
// RULE_07 - Entering a busy bank halts: flag inactive, data still driven.
// RULE_08 - Wrap modes stay inside the aligned 8- or 16-word group.
// RULE_09 - 8-word wrap gives at most 8 words and no inserted waits.
// RULE_10 - After 8-word wrap the eighth word stays driven until terminated.
// RULE_11 - 16-word wrap may wait at the first half-to-half crossing.
// RULE_12 - Wrap modes never insert 128-word crossing waits.
// RULE_13 - Reset returns to idle and restores the configuration default.
// RULE_14 - Host writes the configuration before any burst read.
// RULE_15 - Configuration word can be read back.
// RULE_16 - Bit 15: 0 synchronous burst, 1 asynchronous (default).
// RULE_17 - Bits 14..11: codes 1..11 give first data on edge 3..13.
// RULE_18 - Bit 10: flag polarity, 0 active low, 1 active high (default).
// RULE_19 - Bit 8: 0 flag one clock early, 1 flag with data (default).
// RULE_20 - Bit 7: 0 full drive (default), 1 half drive.
// RULE_21 - Reserved bits reset to 9=1, 6=1, 5=0.
// RULE_22 - Bits 2..0: 000 continuous, 010 8-word wrap, 011 16-word wrap.
// RULE_23 - After latency one word per rising edge, address counter advances.
// RULE_24 - Flag marks initial latency and every inserted wait state.
// RULE_25 - Host never programs reserved latency codes.
`default_nettype none
package fbrl_pkg;

  localparam int          DATA_W          = 16;
  localparam int          ADDR_W          = 25;
  localparam int          BANK_W          = 4;
  localparam int          FIFO_DEPTH      = 8;
  localparam logic [15:0] CFG_RESET       = 16'hDF48;
  localparam int          CFG_MODE_BIT    = 15;
  localparam int          CFG_LAT_LSB     = 11;
  localparam int          CFG_POL_BIT     = 10;
  localparam int          CFG_TIMING_BIT  = 8;
  localparam int          CFG_DRIVE_BIT   = 7;
  localparam logic [2:0]  LEN_CONTINUOUS  = 3'h0;
  localparam logic [2:0]  LEN_WRAP8       = 3'h2;
  localparam logic [2:0]  LEN_WRAP16      = 3'h3;
  localparam logic [3:0]  LAT_EDGE_OFFSET = 4'h2;
  localparam logic [3:0]  LAT_CAP_8       = 4'h8;
  localparam logic [3:0]  LAT_9           = 4'h9;
  localparam logic [3:0]  GROUP_WORDS     = 4'h8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbrl_word_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LATENCY,
    ST_DATA,
    ST_WAIT,
    ST_HALT,
    ST_HOLD
  } fbrl_state_e;

endpackage : fbrl_pkg
`default_nettype wire

// *** hw/fbrl_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbrl_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,    // System clock
  input  wire logic             arst_n,   // Async reset
  input  wire logic             flush,    // Drop all contents
  input  wire logic             inValid,  // Push request
  output logic                  inReady,  // Room available
  input  wire logic [WIDTH-1:0] inData,   // Push word
  output logic                  outValid, // Word available
  input  wire logic             outReady, // Pop request
  output logic      [WIDTH-1:0] outData   // Head word
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_r;
  logic [PW-1:0]    rdPtr_r;
  logic [PW:0]      count_r;
  logic             push;
  logic             pop;

  // Full compare at the count's own width, so DEPTH is not truncated to zero
  assign inReady  = (count_r != (PW+1)'(DEPTH)) && !flush;
  assign outValid = (count_r != '0) && !flush;
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (pop) begin
        rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : fbrl_fifo
`default_nettype wire

// *** hw/fbrl_burst_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbrl_burst_engine #(
  parameter int ADDR_W = fbrl_pkg::ADDR_W,
  parameter int BANK_W = fbrl_pkg::BANK_W,
  parameter int DEPTH  = fbrl_pkg::FIFO_DEPTH
) (
  input  wire logic                        clock,                  // 100 MHz system clock
  input  wire logic                        arst_n,                 // Hardware or power-up reset
  input  wire logic                        burstClk,               // Host burst clock pin
  input  wire logic                        chipSelect_n,           // Chip select pin
  input  wire logic                        outputEnable_n,         // Output enable pin
  input  wire logic                        address_latch_strobe_n, // Address latch strobe pin
  input  wire logic [ADDR_W-1:0]           addrIn,                 // Address pins
  output logic      [fbrl_pkg::DATA_W-1:0] dataOut,                // Data pins, output value
  output logic                             dataOe,                 // Data pins driven
  output logic                             readyFlag,              // Ready flag pin level
  output logic                             readyOe,                // Ready flag driven
  output logic                             driveHalf,              // Output drive strength select
  input  wire logic                        cfgWrEn,                // Configuration-set strobe
  input  wire logic [15:0]                 cfgWrData,              // Configuration-set value
  output logic      [15:0]                 cfgRdData,              // Configuration readback
  output logic      [ADDR_W-1:0]           arrayAddr,              // Array fetch address
  input  wire logic [fbrl_pkg::DATA_W-1:0] arrayData,              // Array word at arrayAddr
  input  wire logic [(1<<BANK_W)-1:0]      bankBusy                // Bank programming or erasing
);

  // ****************************************************************
  // Pin synchronisers and edge detect
  // ****************************************************************
  logic [1:0]        clkSync_r;
  logic [1:0]        csSync_r;
  logic [1:0]        oeSync_r;
  logic [1:0]        strobeSync_r;
  logic [ADDR_W-1:0] addrMeta_r;
  logic [ADDR_W-1:0] addrSync_r;
  logic              clkPrev_r;
  logic              clkRise;
  logic              csActive;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clkSync_r    <= 2'h0;
      csSync_r     <= 2'h3;
      oeSync_r     <= 2'h3;
      strobeSync_r <= 2'h3;
      addrMeta_r   <= '0;
      addrSync_r   <= '0;
      clkPrev_r    <= 1'b0;
    end else begin
      clkSync_r    <= {clkSync_r[0], burstClk};
      csSync_r     <= {csSync_r[0], chipSelect_n};
      oeSync_r     <= {oeSync_r[0], outputEnable_n};
      strobeSync_r <= {strobeSync_r[0], address_latch_strobe_n};
      addrMeta_r   <= addrIn;
      addrSync_r   <= addrMeta_r;
      clkPrev_r    <= clkSync_r[1];
    end
  end

  assign clkRise  = clkSync_r[1] && !clkPrev_r;
  assign csActive = !csSync_r[1];

  // ****************************************************************
  // Configuration word
  // ****************************************************************
  logic [15:0] cfg_r;
  logic [2:0]  burstLen;
  logic [3:0]  initWaits;
  logic        syncMode;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r <= fbrl_pkg::CFG_RESET; // RULE_13 RULE_21
    end else if (cfgWrEn) begin
      cfg_r <= cfgWrData;
    end
  end

  assign cfgRdData = cfg_r; // RULE_15
  assign syncMode  = !cfg_r[fbrl_pkg::CFG_MODE_BIT]; // RULE_16
  assign initWaits = cfg_r[fbrl_pkg::CFG_LAT_LSB +: 4] + fbrl_pkg::LAT_EDGE_OFFSET; // RULE_17
  assign burstLen  = cfg_r[2:0]; // RULE_22
  assign driveHalf = cfg_r[fbrl_pkg::CFG_DRIVE_BIT]; // RULE_20

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a, input logic [2:0] len);
    logic [ADDR_W-1:0] inc;
    inc = a + 1'b1;
    case (len)
      fbrl_pkg::LEN_WRAP8:  nextAddr = {a[ADDR_W-1:3], inc[2:0]}; // RULE_08
      fbrl_pkg::LEN_WRAP16: nextAddr = {a[ADDR_W-1:4], inc[3:0]}; // RULE_08
      default:              nextAddr = inc; // RULE_05
    endcase
  endfunction : nextAddr

  // Waits at the first 8-word crossing; settings above 8 behave like 8
  function automatic logic [3:0] groupWaits(input logic [3:0] n, input logic [2:0] w);
    logic [3:0] neff;
    logic [3:0] room;
    neff = (n > fbrl_pkg::LAT_CAP_8) ? fbrl_pkg::LAT_CAP_8 : n; // RULE_03
    room = fbrl_pkg::GROUP_WORDS - {1'b0, w};
    groupWaits = (neff > room) ? neff - room : 4'h0; // RULE_02
  endfunction : groupWaits

  function automatic logic [3:0] bigWaits(input logic [3:0] n);
    if (n > fbrl_pkg::LAT_9) begin
      bigWaits = 4'h2;
    end else if (n == fbrl_pkg::LAT_9) begin
      bigWaits = 4'h1;
    end else begin
      bigWaits = 4'h0;
    end // RULE_04
  endfunction : bigWaits

  // ****************************************************************
  // Array fetch into the word buffer
  // ****************************************************************
  localparam int WORD_W = $bits(fbrl_pkg::fbrl_word_s);

  fbrl_pkg::fbrl_word_s pushWord;
  fbrl_pkg::fbrl_word_s headWord;
  logic                 fetchActive_r;
  logic [ADDR_W-1:0]    fetchAddr_r;
  logic [3:0]           fetchCount_r;
  logic                 fifoInReady;
  logic                 fifoOutValid;
  logic                 fifoFlush;
  logic                 pop;
  logic                 startBurst;
  logic                 endBurst;

  assign startBurst = clkRise && csActive && !strobeSync_r[1] && syncMode;
  assign endBurst   = !csActive;
  assign fifoFlush  = startBurst || endBurst;
  assign arrayAddr  = fetchAddr_r;
  assign pushWord   = '{addr: fetchAddr_r, data: arrayData};

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fetchActive_r <= 1'b0;
      fetchAddr_r   <= '0;
      fetchCount_r  <= 4'h0;
    end else if (startBurst) begin
      fetchActive_r <= 1'b1;
      fetchAddr_r   <= addrSync_r;
      fetchCount_r  <= 4'h0;
    end else if (endBurst) begin
      fetchActive_r <= 1'b0;
    end else if (fetchActive_r && fifoInReady) begin
      fetchAddr_r  <= nextAddr(fetchAddr_r, burstLen); // RULE_23
      fetchCount_r <= fetchCount_r + 1'b1;
      if (burstLen == fbrl_pkg::LEN_WRAP8 && fetchCount_r == 4'h7) begin
        fetchActive_r <= 1'b0; // RULE_09
      end
    end
  end

  fbrl_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock    (clock),
    .arst_n   (arst_n),
    .flush    (fifoFlush),
    .inValid  (fetchActive_r),
    .inReady  (fifoInReady),
    .inData   (pushWord),
    .outValid (fifoOutValid),
    .outReady (pop),
    .outData  (headWord)
  );

  // ****************************************************************
  // Burst output sequencer
  // ****************************************************************
  fbrl_pkg::fbrl_state_e state_r;
  logic [3:0]            cnt_r;
  logic [2:0]            startOfs_r;
  logic                  firstWord_r;
  logic                  crossed_r;
  logic [3:0]            wordsOut_r;
  logic [ADDR_W-1:0]     lastAddr_r;
  logic                  dataValid_r;
  logic [3:0]            crossWaits;
  logic                  groupCross;
  logic                  bankCross;
  logic                  bigCross;
  logic                  headBusy;
  logic                  presentNext;
  logic [BANK_W-1:0]     headBank;

  assign headBank   = headWord.addr[ADDR_W-1 -: BANK_W];
  assign headBusy   = bankBusy[headBank];
  assign groupCross = !firstWord_r && !crossed_r && headWord.addr[2:0] == 3'h0
                      && burstLen != fbrl_pkg::LEN_WRAP8; // RULE_09 RULE_11
  assign bigCross   = !firstWord_r && burstLen == fbrl_pkg::LEN_CONTINUOUS
                      && headWord.addr[6:0] == 7'h00; // RULE_12
  assign bankCross  = bigCross && headBank != lastAddr_r[ADDR_W-1 -: BANK_W];

  always_comb begin
    crossWaits = 4'h0;
    if (groupCross) begin
      crossWaits = groupWaits(initWaits, startOfs_r); // RULE_02 RULE_11
    end
    if (bigCross) begin
      crossWaits = crossWaits + bigWaits(initWaits); // RULE_04 RULE_06
    end
  end

  // Word presented at this edge: latency or wait expiring, or a plain data step
  always_comb begin
    pop = 1'b0;
    if (clkRise && fifoOutValid && !fifoFlush) begin
      case (state_r)
        fbrl_pkg::ST_LATENCY: pop = (cnt_r == 4'h1);
        fbrl_pkg::ST_WAIT:    pop = (cnt_r == 4'h1);
        fbrl_pkg::ST_DATA:    pop = crossWaits == 4'h0 && !(bankCross && headBusy)
                                    && !(burstLen == fbrl_pkg::LEN_WRAP8 && wordsOut_r == 4'h8);
        default:              pop = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r     <= fbrl_pkg::ST_IDLE; // RULE_13
      cnt_r       <= 4'h0;
      startOfs_r  <= 3'h0;
      firstWord_r <= 1'b1;
      crossed_r   <= 1'b0;
      wordsOut_r  <= 4'h0;
      lastAddr_r  <= '0;
    end else if (endBurst) begin
      state_r <= fbrl_pkg::ST_IDLE; // RULE_05
    end else if (startBurst) begin
      state_r     <= fbrl_pkg::ST_LATENCY; // RULE_05
      cnt_r       <= initWaits; // RULE_17
      startOfs_r  <= addrSync_r[2:0];
      firstWord_r <= 1'b1;
      crossed_r   <= 1'b0;
      wordsOut_r  <= 4'h0;
    end else if (clkRise) begin
      case (state_r)
        fbrl_pkg::ST_LATENCY,
        fbrl_pkg::ST_WAIT: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (pop) begin
            state_r <= fbrl_pkg::ST_DATA;
          end
        end
        fbrl_pkg::ST_DATA: begin
          if (burstLen == fbrl_pkg::LEN_WRAP8 && wordsOut_r == 4'h8) begin
            state_r <= fbrl_pkg::ST_HOLD; // RULE_10
          end else if (fifoOutValid && bankCross && headBusy) begin
            state_r <= fbrl_pkg::ST_HALT; // RULE_07
          end else if (fifoOutValid && crossWaits != 4'h0) begin
            state_r   <= fbrl_pkg::ST_WAIT;
            cnt_r     <= crossWaits;
            crossed_r <= crossed_r || groupCross;
          end
        end
        default: state_r <= state_r;
      endcase
      if (pop) begin
        firstWord_r <= 1'b0;
        lastAddr_r  <= headWord.addr;
        wordsOut_r  <= wordsOut_r + 1'b1;
        if (groupCross) begin
          crossed_r <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Data pins and ready flag
  // ****************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dataOut     <= '0;
      dataValid_r <= 1'b0;
    end else if (fifoFlush) begin
      dataValid_r <= 1'b0;
    end else if (clkRise) begin
      if (pop) begin
        dataOut     <= headWord.data; // RULE_23
        dataValid_r <= 1'b1;
      end else if (state_r != fbrl_pkg::ST_HOLD
                   && !(burstLen == fbrl_pkg::LEN_WRAP8 && wordsOut_r == 4'h8)) begin
        // Eighth word of a wrap stays valid on the edge that enters the hold
        dataValid_r <= 1'b0; // RULE_24 RULE_10
      end
    end
  end

  // Early flag looks ahead at what the next edge will do
  always_comb begin
    case (state_r)
      fbrl_pkg::ST_LATENCY,
      fbrl_pkg::ST_WAIT: presentNext = (cnt_r == 4'h1);
      fbrl_pkg::ST_DATA: presentNext = (burstLen == fbrl_pkg::LEN_WRAP8 && wordsOut_r == 4'h8) // RULE_10
                                       || (fifoOutValid && crossWaits == 4'h0 && !(bankCross && headBusy));
      fbrl_pkg::ST_HOLD: presentNext = 1'b1;
      default:           presentNext = 1'b0;
    endcase
  end

  logic readyActive;

  assign readyActive = cfg_r[fbrl_pkg::CFG_TIMING_BIT] ? dataValid_r : presentNext; // RULE_19 RULE_24
  assign readyFlag   = readyActive ~^ cfg_r[fbrl_pkg::CFG_POL_BIT]; // RULE_18
  assign readyOe     = csActive && syncMode;
  // Halted burst keeps the bus driven with the flag held inactive
  assign dataOe      = csActive && !oeSync_r[1] && syncMode && state_r != fbrl_pkg::ST_IDLE; // RULE_07

endmodule : fbrl_burst_engine
`default_nettype wire

// *** verif/fbrl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbrl_asserts (
  input wire logic                        clock,                  // System clock
  input wire logic                        arst_n,                 // Async reset
  input wire logic                        burstClk,               // Burst clock pin
  input wire logic                        chipSelect_n,           // Chip select pin
  input wire logic                        address_latch_strobe_n, // Latch strobe pin
  input wire logic [fbrl_pkg::DATA_W-1:0] dataOut,                // Data value
  input wire logic                        dataOe,                 // Data driven
  input wire logic                        readyFlag,              // Flag level
  input wire logic                        readyOe,                // Flag driven
  input wire logic                        driveHalf,              // Drive select
  input wire logic                        cfgWrEn,                // Config write
  input wire logic [15:0]                 cfgWrData,              // Config value
  input wire logic [15:0]                 cfgRdData               // Config readback
);
  // ****************
  // Edge tracking
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic       clkPin_r;
  logic [3:0] sinceRise_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clkPin_r    <= 1'b0;
      sinceRise_r <= 4'hF;
    end else begin
      clkPin_r    <= burstClk;
      sinceRise_r <= (burstClk && !clkPin_r) ? 4'h0 : ((sinceRise_r == 4'hF) ? 4'hF : sinceRise_r + 4'h1);
    end
  end
  // ****************
  // Properties
  // ****************
  sequence s_latch;
    $rose(burstClk) && !address_latch_strobe_n && !chipSelect_n && !cfgRdData[15];
  endsequence
  // Latency is at least three edges; the flag is checked inactive for 8 clocks starting 6 clocks after the latch edge
  sequence s_quiet;
    (readyFlag != cfgRdData[10]) [*8];
  endsequence
  a_reset_default: assert property ($rose(arst_n) |-> cfgRdData == fbrl_pkg::CFG_RESET && !driveHalf)
    else $error("config not at default after reset");
  a_cfg_readback: assert property (cfgWrEn |=> cfgRdData == $past(cfgWrData))
    else $error("config readback wrong");
  a_cfg_holds: assert property (!cfgWrEn |=> $stable(cfgRdData))
    else $error("config changed without write");
  a_drive_select: assert property (cfgWrEn |=> driveHalf == $past(cfgWrData[7]))
    else $error("drive select not from config");
  a_cs_ends: assert property (chipSelect_n [*4] |-> !dataOe && !readyOe)
    else $error("outputs driven without chip select");
  a_async_quiet: assert property (cfgRdData[15] [*2] |-> !dataOe && !readyOe)
    else $error("burst outputs in async mode");
  a_data_at_edge: assert property ($changed(dataOut) && !chipSelect_n |-> sinceRise_r inside {[1:7]})
    else $error("data changed away from a clock edge");
  a_latency_flag: assert property (s_latch |-> ##6 s_quiet)
    else $error("flag active during initial latency");
endmodule : fbrl_asserts
bind fbrl_burst_engine fbrl_asserts u_asserts (
  .clock, .arst_n, .burstClk, .chipSelect_n, .address_latch_strobe_n, .dataOut, .dataOe,
  .readyFlag, .readyOe, .driveHalf, .cfgWrEn, .cfgWrData, .cfgRdData
);
`default_nettype wire

// *** verif/fbrl_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbrl_host_model (
  input  wire logic        clock,                  // System clock
  output logic             burstClk,               // Burst clock, still between bursts
  output logic             chipSelect_n,           // Chip select
  output logic             outputEnable_n,         // Output enable
  output logic             address_latch_strobe_n, // Address strobe
  output logic [24:0]      addrIn,                 // Word address
  input  wire logic [15:0] dataOut,                // Data pins
  input  wire logic        dataOe,                 // Data driven
  input  wire logic        readyFlag,              // Flag level
  input  wire logic        readyOe                 // Flag driven
);
  // ****************
  // Burst cycles
  // ****************
  logic [18:0] smp [0:47];
  initial begin
    burstClk = 1'b0;
    chipSelect_n = 1'b1;
    outputEnable_n = 1'b1;
    address_latch_strobe_n = 1'b1;
    addrIn = 25'h0000000;
  end
  // Samples one cycle before each rise, so each entry shows the state after the previous edge
  task automatic burst(input logic [24:0] a, input int edges, input logic endCs);
    int k;
    @(negedge clock);
    chipSelect_n = 1'b0;
    outputEnable_n = 1'b1;
    address_latch_strobe_n = 1'b0;
    addrIn = a;
    repeat (4) @(negedge clock);
    for (k = 0; k <= edges; k++) begin
      burstClk = 1'b1;
      repeat (4) @(negedge clock);
      burstClk = 1'b0;
      address_latch_strobe_n = 1'b1;
      outputEnable_n = 1'b0;
      // Released address bus keeps toggling
      addrIn = ~addrIn;
      repeat (3) @(negedge clock);
      smp[k] = {readyOe, dataOe, readyFlag, dataOut};
      @(negedge clock);
    end
    if (endCs) begin
      chipSelect_n = 1'b1;
      outputEnable_n = 1'b1;
      repeat (4) @(negedge clock);
    end
  endtask : burst
endmodule : fbrl_host_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************
  // Signals and models
  // ****************
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic        cfgWrEn = 1'b0;
  logic [15:0] cfgWrData = 16'h0000;
  logic [15:0] bankBusy = 16'h0000;
  logic [15:0] cfgRdData, dataOut, arrayData, cfg;
  logic [24:0] addrIn, arrayAddr, a;
  logic        burstClk, chipSelect_n, outputEnable_n, address_latch_strobe_n;
  logic        dataOe, readyFlag, readyOe, driveHalf;
  int          num_errors = 0;
  int          num_checks = 0;
  integer      seed = 32'h8FADF727;
  int          i, k, n;
  localparam logic [24:0] CORNER [0:3] = '{25'h000007B, 25'h01FFFFA, 25'h01FFFFA, 25'h1FFFFFD};

  function automatic logic [15:0] mem_word(input logic [24:0] w);
    return w[15:0] ^ {w[24:16], 7'h2B};
  endfunction : mem_word

  always #5 clock = ~clock;
  assign arrayData = mem_word(arrayAddr);

  fbrl_burst_engine dut (
    .clock, .arst_n, .burstClk, .chipSelect_n, .outputEnable_n, .address_latch_strobe_n, .addrIn,
    .dataOut, .dataOe, .readyFlag, .readyOe, .driveHalf, .cfgWrEn, .cfgWrData, .cfgRdData,
    .arrayAddr, .arrayData, .bankBusy
  );
  fbrl_host_model host (
    .clock, .burstClk, .chipSelect_n, .outputEnable_n, .address_latch_strobe_n, .addrIn,
    .dataOut, .dataOe, .readyFlag, .readyOe
  );

  // ****************
  // Checking tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_cfg(input logic [15:0] v);
    @(negedge clock);
    cfgWrEn = 1'b1;
    cfgWrData = v;
    @(negedge clock);
    cfgWrEn = 1'b0;
    chk(cfgRdData, v);
    chk(driveHalf, v[7]);
  endtask : wr_cfg

  // Walks the edges of a burst and predicts flag and data for each
  task automatic check_burst(input logic [24:0] s, input int edges, input logic [15:0] c);
    logic [24:0] cur, nxt;
    logic        vld [0:48];
    logic [15:0] dat [0:48];
    logic        crossed, halt;
    int          lat, wt, words, e;
    lat = int'(c[14:11]) + 2;
    cur = s;
    crossed = 1'b0;
    halt = 1'b0;
    wt = 0;
    words = 0;
    for (e = 0; e <= edges + 1; e++) begin
      vld[e] = 1'b0;
      dat[e] = 16'h0000;
      if (e < lat || halt) continue;
      if (wt > 0) begin
        wt--;
        continue;
      end
      vld[e] = 1'b1;
      dat[e] = mem_word(cur);
      words++;
      if (c[2:0] == fbrl_pkg::LEN_WRAP8 && words >= 8) continue;
      case (c[2:0])
        fbrl_pkg::LEN_WRAP8: nxt = {cur[24:3], cur[2:0] + 3'h1};
        fbrl_pkg::LEN_WRAP16: nxt = {cur[24:4], cur[3:0] + 4'h1};
        default: nxt = cur + 25'h1;
      endcase
      if (c[2:0] != fbrl_pkg::LEN_WRAP8 && nxt[2:0] == 3'h0 && !crossed) begin
        crossed = 1'b1;
        wt = ((lat > 8) ? 8 : lat) - (8 - int'(s[2:0]));
        if (wt < 0) wt = 0;
      end
      if (c[2:0] == fbrl_pkg::LEN_CONTINUOUS && nxt[6:0] == 7'h00) begin
        wt += (lat <= 8) ? 0 : ((lat == 9) ? 1 : 2);
        if (bankBusy[nxt[24:21]] && nxt[24:21] != cur[24:21]) halt = 1'b1;
      end
      cur = nxt;
    end
    for (e = 1; e <= edges; e++) begin
      chk(host.smp[e][18:17], 2'h3);
      chk(host.smp[e][16] == c[10], c[8] ? vld[e] : vld[e + 1]);
      if (vld[e]) chk(host.smp[e][15:0], dat[e]);
    end
  endtask : check_burst

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (100000) @(posedge clock);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    chk(cfgRdData, fbrl_pkg::CFG_RESET);
    chk(driveHalf, 1'b0);
    host.burst(25'h0000010, 6, 1'b1);
    for (k = 1; k <= 6; k++) begin
      chk(host.smp[k][18:17], 2'h0);
    end
    $display("async test done");
    for (i = 0; i < 28; i++) begin
      a = 25'($random(seed));
      cfg = 16'($random(seed));
      bankBusy = 16'($random(seed));
      bankBusy[a[24:21]] = 1'b0;
      cfg[14:11] = (i < 11) ? 4'(i + 1) : cfg[14:11] % 4'hB + 4'h1;
      cfg[2:0] = (i % 3 == 1) ? fbrl_pkg::LEN_WRAP8 : ((i % 3 == 2) ? fbrl_pkg::LEN_WRAP16 : fbrl_pkg::LEN_CONTINUOUS);
      // Boundary, bank and top-of-array crossings with long latencies
      if (i >= 6 && i <= 9) begin
        a = CORNER[i - 6];
        bankBusy = (i == 7) ? 16'h0001 : 16'h0000;
        cfg[2:0] = fbrl_pkg::LEN_CONTINUOUS;
      end
      cfg[15] = 1'b0;
      cfg[9:3] = {1'b1, cfg[8], cfg[7], 4'h9};
      wr_cfg(cfg);
      n = int'(cfg[14:11]) + 22;
      host.burst(a, n, i != 12 && i != 27);
      check_burst(a, n, cfg);
      $display("burst %0d done", i);
    end
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    chk(cfgRdData, fbrl_pkg::CFG_RESET);
    chk({dataOe, readyOe, driveHalf}, 3'h0);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    chk({dataOe, readyOe}, 2'h0);
    $display("reset test done");
    end_sim();
  end
endmodule : testbench
`default_nettype wire
